// ===== include/wdg_cnt_if.sv
// Carrier between the watchdog register logic and its timeout counter
`timescale 1ns/1ns
interface wdg_cnt_if;
    import wdg_pkg::*;
    logic tick;           // One cycle per watchdog oscillator rising edge
    logic clear;          // Restart or chip reset
    logic enable;         // Watchdog running
    wdg_presc_t prescale; // Timeout code
    logic expire;         // Timeout reached on this tick
    modport ctrl (output tick, output clear, output enable, output prescale, input expire);
    modport counter (input tick, input clear, input enable, input prescale, output expire);
endinterface

// ===== include/wdg_defs.svh
// Offsets, field positions, reset values and timing counts of the watchdog block
`ifndef WDG_DEFS_SVH
`define WDG_DEFS_SVH

// Register byte offsets on the AXI4-Lite bus
`define WDG_OFF_STATUS 8'h00
`define WDG_OFF_CTRL 8'h04
`define WDG_OFF_RESTART 8'h08

// Reset-cause status field positions
`define WDG_ST_POWER_ON 0
`define WDG_ST_EXT_PIN 1
`define WDG_ST_BROWNOUT 2
`define WDG_ST_WATCHDOG 3
`define WDG_ST_TEST_PORT 4
`define WDG_ST_MSB 4
`define WDG_ST_RESET 5'h01

// Watchdog control field positions
`define WDG_CT_PRESC_MSB 2
`define WDG_CT_ENABLE 3
`define WDG_CT_CHANGE 4
`define WDG_RESTART_BIT 0

// Clock rates, change window and timeout base
`define WDG_SYS_HZ 10000000
`define WDG_OSC_HZ 1000000
`define WDG_CHANGE_WINDOW 3'h4
// Cycles the fuse strap is sampled after reset release
`define WDG_FUSE_SETTLE 2'h3
`define WDG_TIMEOUT_BASE 16384
`define WDG_CNT_W 21
`define WDG_ADDR_W 8

// Bus answers
`define WDG_RESP_OKAY 2'h0
`define WDG_RESP_SLVERR 2'h2

// Synchroniser lanes for inputs from outside the clock domain
`define WDG_SY_OSC 0
`define WDG_SY_EXT 1
`define WDG_SY_BOR 2
`define WDG_SY_TEST 3
`define WDG_SY_FUSE 4
`define WDG_SY_N 5

`endif

// ===== include/wdg_pkg.sv
// Shared types of the watchdog block
package wdg_pkg;
    // Timeout code, 16K oscillator cycles doubled per step
    typedef logic [2:0] wdg_presc_t;
    // One register byte
    typedef logic [7:0] wdg_byte_t;
    // Change window down-counter
    typedef logic [2:0] wdg_win_t;
    // Reset-cause flags, power-on in bit 0
    typedef logic [4:0] wdg_flags_t;
endpackage

// ===== rtl/wdg_counter.sv
// Watchdog timeout counter paced by oscillator ticks
`timescale 1ns/1ns
`include "wdg_defs.svh"
module wdg_counter
    import wdg_pkg::*;
#(
    parameter int TIMEOUT_BASE = `WDG_TIMEOUT_BASE,
    parameter int CNT_W = `WDG_CNT_W
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    wdg_cnt_if.counter cnt
);
    // Oscillator cycles elapsed since the last restart
    logic [CNT_W-1:0] count;
    // Last tick count before a timeout, base doubled per code step
    wire [CNT_W-1:0] terminal = CNT_W'((TIMEOUT_BASE << cnt.prescale) - 1);
    // A shortened timeout may leave count above terminal, so compare with >=
    wire atEnd = (count >= terminal);

    // Timeout fires only on a tick while running and not being restarted
    // Timeout triggers reset
    assign cnt.expire = cnt.tick && cnt.enable && !cnt.clear && atEnd;

    // Counter advance and clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (cnt.clear || !cnt.enable) begin
            count <= '0;
        end else if (cnt.tick) begin
            count <= atEnd ? '0 : count + CNT_W'(1);
        end
    end
endmodule // wdg_counter

// ===== rtl/wdg_top.sv
// Watchdog with timed change sequence and reset-cause flags, AXI4-Lite slave
//
// How it works
// - Counter paced by separate 1 MHz oscillator
// - Restart, disable or chip reset clears counter
// - Timeout elapsed resets the device
// - Fuse picks safety level and start state
// - Level 1: enable anytime, no sequence
// - Level 2: always enabled, reads one
// - Level 2: timeout change, enable value ignored
// - Level 2: disable always refused
// - Change-enable self-clears after four cycles
// - Disable or prescale change needs window
// - Control bits 7:5 read zero
// - Code 000 is 16K, doubling per step
// - Bit 4: test-port reset flag
// - Bit 3: watchdog reset flag
// - Bit 2: brown-out reset flag
// - Bit 1: external pin reset flag
// - Bit 0: power-on flag, software clears
// - Timeout gives one-cycle internal reset pulse
`timescale 1ns/1ns
`include "wdg_defs.svh"
module wdg_top
    import wdg_pkg::*;
#(
    parameter int TIMEOUT_BASE = `WDG_TIMEOUT_BASE,
    parameter int CNT_W = `WDG_CNT_W,
    parameter int ADDR_W = `WDG_ADDR_W
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    // Watchdog oscillator, sampled as a plain input
    input wire logic wdtOscIn,
    // Reset sources outside this block, active high levels
    input wire logic extPinReset,
    input wire logic brownoutReset,
    input wire logic testPortCoreReset,
    // Programmed fuse selects safety level 2
    input wire logic watchdogAlwaysOnFuse,
    // Restart instruction from the core, same clock
    input wire logic restartInstr,
    // AXI4-Lite write address channel
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // Write data channel
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // Write response channel
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read address channel
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // Read data channel
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Internal reset request, one system clock wide
    output logic wdtResetPulse,
    // Watchdog currently running
    output logic watchdogActive
);

    // Address match against one register word; used by read and write decode
    // Low two address bits are ignored, so byte offsets inside a word alias
    function automatic logic isReg(input logic [ADDR_W-1:0] addr, input logic [7:0] off);
        isReg = (addr[ADDR_W-1:2] == off[ADDR_W-1:2]);
    endfunction

    // Input synchronisers
    // Every lane from outside clk_sys passes two flops before any logic reads it
    // Trade-off: two cycles of latency on each pin for metastability margin
    wire [`WDG_SY_N-1:0] rawIn = {watchdogAlwaysOnFuse, testPortCoreReset, brownoutReset, extPinReset, wdtOscIn};
    logic [`WDG_SY_N-1:0] syncA;   // First stage, read only by syncB
    logic [`WDG_SY_N-1:0] syncB;   // Second stage, safe to use
    // Reset value 0 equals the idle level of every lane, so no false edge follows reset

    // Two flops per lane; pins are asynchronous to clk_sys
    // Two-flop input crossing
    genvar gi;
    generate
        for (gi = 0; gi < `WDG_SY_N; gi++) begin : gSync
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    syncA[gi] <= 1'b0;
                    syncB[gi] <= 1'b0;
                end else begin
                    syncA[gi] <= rawIn[gi];
                    syncB[gi] <= syncA[gi];
                end
            end
        end
    endgenerate

    // Synchronised reset sources, each high while its source is active
    wire extSync = syncB[`WDG_SY_EXT];
    wire borSync = syncB[`WDG_SY_BOR];
    wire testSync = syncB[`WDG_SY_TEST];

    // Edge detect on the synchronised oscillator; needs osc below half clk_sys
    logic oscPrev;
    wire oscTick = syncB[`WDG_SY_OSC] && !oscPrev;
    // Previous oscillator level; one tick per rising edge

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            oscPrev <= 1'b0;
        end else begin
            oscPrev <= syncB[`WDG_SY_OSC];
        end
    end

    // Fuse capture: strap is sampled on the first three cycles after release, then frozen
    // The strap is sampled until the settle count is reached
    // A strap that changes later is ignored until the next power-on
    logic [1:0] fuseWait;   // Lets the synchroniser fill first
    logic level2;           // Safety level 2 selected
    // Level 1 until the strap has been sampled, so enable reads 0 meanwhile

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fuseWait <= 2'h0;
            level2 <= 1'b0;
        end else if (fuseWait != `WDG_FUSE_SETTLE) begin
            fuseWait <= fuseWait + 2'h1;
            level2 <= syncB[`WDG_SY_FUSE];
        end
    end

    // AXI4-Lite write path: address and data taken in either order
    // Each half is held until the response is accepted, so one write at a time
    // The register update happens one cycle after the later half arrives
    logic [ADDR_W-1:0] wrAddr;  // Held write address
    logic [31:0] wrData;        // Held write data
    logic [3:0] wrStrb;         // Held byte enables

    // Both halves held and no answer pending: perform the write
    wire doWrite = !awready && !wready && !bvalid;
    // Holding both halves lets address and data arrive in either order
    wire wrHitStatus = isReg(wrAddr, `WDG_OFF_STATUS);
    wire wrHitCtrl = isReg(wrAddr, `WDG_OFF_CTRL);
    wire wrHitRestart = isReg(wrAddr, `WDG_OFF_RESTART);
    wire wrMapped = wrHitStatus || wrHitCtrl || wrHitRestart;
    // Only byte lane 0 carries register bits
    wire wrLane0 = doWrite && wrStrb[0];
    wire wrStatus = wrLane0 && wrHitStatus;
    wire wrCtrl = wrLane0 && wrHitCtrl;
    wire wrRestart = wrLane0 && wrHitRestart && wrData[`WDG_RESTART_BIT];

    // Write channel handshakes and response
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= `WDG_RESP_OKAY;
            wrAddr <= '0;
            wrData <= 32'h0000_0000;
            wrStrb <= 4'h0;
        end else begin
            // Address taken, hold until response is accepted
            if (awvalid && awready) begin
                awready <= 1'b0;
                wrAddr <= awaddr;
            end
            // Data taken independently of the address
            if (wvalid && wready) begin
                wready <= 1'b0;
                wrData <= wdata;
                wrStrb <= wstrb;
            end
            // Answer; unmapped word gets SLVERR
            if (doWrite) begin
                bvalid <= 1'b1;
                bresp <= wrMapped ? `WDG_RESP_OKAY : `WDG_RESP_SLVERR;
            end else if (bvalid && bready) begin
                // Response taken: both channels reopen together
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // Watchdog control register
    // The window counter loads on the apply edge of the opening write and
    // counts down once per clk_sys cycle; a closing write must land while
    // it is non-zero. Back-to-back bus writes land three cycles apart, so a
    // master that idles more than one cycle between them misses the window
    logic enableBit;         // Software enable, level 1 meaning
    wdg_presc_t prescale;    // Active timeout code
    wdg_win_t winCnt;        // Cycles left in change window
    wire winOpen = (winCnt != 3'h0);
    wire effEnable = enableBit || level2;

    // Fields of the held write word, decoded once for all branches
    wire wCe = wrData[`WDG_CT_CHANGE];
    wire wEn = wrData[`WDG_CT_ENABLE];
    wire [2:0] wPs = wrData[`WDG_CT_PRESC_MSB:0];

    // Any chip reset except power-on, which is rst_n itself
    wire chipReset = extSync || borSync || testSync || wdtResetPulse;

    // Control state: chip reset returns it to the fuse default
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            enableBit <= 1'b0;
            prescale <= 3'h0;
            winCnt <= 3'h0;
        end else if (chipReset) begin
            // Software state back to defaults; level 2 stays on through the fuse
            enableBit <= 1'b0;
            prescale <= 3'h0;
            winCnt <= 3'h0;
        end else if (wrCtrl && wCe && wEn) begin
            winCnt <= `WDG_CHANGE_WINDOW;
            enableBit <= 1'b1;
        end else if (wrCtrl && winOpen && !wCe) begin
            prescale <= wPs;
            if (!level2) begin
                enableBit <= wEn;
            end
            winCnt <= 3'h0;
        end else begin
            // Neither opening nor closing: only enable 0 to 1 is taken
            // Free enable, no window
            if (wrCtrl && wEn) begin
                enableBit <= 1'b1;
            end
            if (winOpen) begin
                winCnt <= winCnt - 3'h1;
            end
        end
    end

    // Control readback; change bit reads one while the window is open
    // Reserved bits read zero
    wire [7:0] ctrlRead = {3'h0, winOpen, effEnable, prescale};

    // Reset-cause flags; a set in the clearing cycle wins
    // Causes accumulate until software clears them, so several may read one
    // Software should read, then clear, early after startup
    wdg_flags_t flags;
    wire [4:0] flagSet = {testSync, wdtResetPulse, borSync, extSync, 1'b0};
    wire [4:0] flagClr = wrStatus ? ~wrData[`WDG_ST_MSB:0] : 5'h00;
    // Set is ORed in after the clear, so a fresh cause is never lost

    // Power-on clears bits 4:1 and sets bit 0; software writes zero to clear
    // Power-on flag set
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flags <= `WDG_ST_RESET;
        end else begin
            flags <= (flags & ~flagClr) | flagSet;
        end
    end

    // Timeout counter and reset pulse
    // The counter runs on oscillator ticks but is clocked by clk_sys, so
    // enable, prescale and restart never cross a clock boundary
    wdg_cnt_if cntBus();
    // Restart comes from the core pin or from a write to the restart word

    assign cntBus.clear = restartInstr || wrRestart || chipReset;
    assign cntBus.tick = oscTick;
    assign cntBus.enable = effEnable;
    assign cntBus.prescale = prescale;

    wdg_counter #(
        .TIMEOUT_BASE(TIMEOUT_BASE),
        .CNT_W(CNT_W)
    ) uCounter (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .cnt(cntBus)
    );

    // Expire is a single tick, so the pulse lasts exactly one cycle
    // One-cycle reset pulse
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wdtResetPulse <= 1'b0;
            watchdogActive <= 1'b0;
        end else begin
            // The pulse itself clears the counter, so it cannot repeat next cycle
            wdtResetPulse <= cntBus.expire;
            watchdogActive <= effEnable;
        end
    end

    // AXI4-Lite read path, answer one cycle after address is taken
    // Data and answer come out of registers; reads have no side effects
    // Unmapped words answer SLVERR with zero data
    wire rdHitStatus = isReg(araddr, `WDG_OFF_STATUS);
    wire rdHitCtrl = isReg(araddr, `WDG_OFF_CTRL);
    wire rdHitRestart = isReg(araddr, `WDG_OFF_RESTART);
    wire rdMapped = rdHitStatus || rdHitCtrl || rdHitRestart;
    // Restart word reads zero; it only acts on write
    wire [7:0] rdByte = rdHitStatus ? {3'h0, flags} : (rdHitCtrl ? ctrlRead : 8'h00);

    // Read channel handshakes; reads have no side effects
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `WDG_RESP_OKAY;
        end else if (arvalid && arready) begin
            // Address taken: capture data now, hold until accepted
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= {24'h00_0000, rdByte};
            rresp <= rdMapped ? `WDG_RESP_OKAY : `WDG_RESP_SLVERR;
        end else if (rvalid && rready) begin
            // Answer taken: accept the next address
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

endmodule // wdg_top

// ===== verification/tb_top.sv
// Self-checking bench for the watchdog top
`timescale 1ns/1ns
`include "wdg_defs.svh"
module tb_top import wdg_pkg::*;;
    localparam int TB = 4; // Short timeout base so code 3 fires within 32 ticks
    localparam logic [7:0] ST = `WDG_OFF_STATUS;
    localparam logic [7:0] CT = `WDG_OFF_CTRL;
    localparam logic [7:0] RS = `WDG_OFF_RESTART;
    localparam logic [1:0] OK = `WDG_RESP_OKAY;
    logic clk_sys, rst_n, wdtOscIn, extPinReset, brownoutReset, testPortCoreReset, watchdogAlwaysOnFuse;
    logic restartInstr, awvalid, wvalid, arvalid, awready, wready, arready, bvalid, rvalid;
    logic wdtResetPulse, watchdogActive;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rng;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [1:0] bq[$]; // Expected write answers
    logic [33:0] rq[$]; // Expected {rresp, rdata}
    logic [7:0] flagBit[3] = '{8'h02, 8'h04, 8'h10}; // Flags for pin, brown-out, test port
    int mismatches = 0, nTests = 0, cyc = 0, nPulse = 0, n0;
    time tPulse, t0;

    wdg_top #(.TIMEOUT_BASE(TB)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .wdtOscIn(wdtOscIn),
        .extPinReset(extPinReset), .brownoutReset(brownoutReset), .testPortCoreReset(testPortCoreReset),
        .watchdogAlwaysOnFuse(watchdogAlwaysOnFuse), .restartInstr(restartInstr), .awaddr(awaddr),
        .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1),
        .wdtResetPulse(wdtResetPulse), .watchdogActive(watchdogActive));

    // System clock, 100 ns
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Watchdog oscillator, 1 us, its edges clear of the sampling edges
    initial begin
        wdtOscIn = 1'b0;
        forever #500 wdtOscIn = ~wdtOscIn;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        nTests++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic cmp_b(input logic [1:0] g, input logic [1:0] e);
        chk(34'(g), 34'(e));
    endtask
    task automatic cmp_r(input logic [33:0] g, input logic [33:0] e);
        chk(g, e);
    endtask
    task automatic cmp_v(input logic [31:0] g, input logic [31:0] e);
        chk(34'(g), 34'(e));
    endtask

    task automatic tally_and_finish();
        if (mismatches == 0 && nTests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Address and data offered together, each released when taken; bready stays high
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        bq.push_back(e);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge clk_sys);
            if (awvalid && awready) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk_sys); while (!bvalid);
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk_sys); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk_sys); while (!rvalid);
    endtask
    task automatic restart_pin();
        restartInstr <= 1'b1;
        @(posedge clk_sys);
        restartInstr <= 1'b0;
    endtask

    // Watcher: pairs answers with the oldest note, counts pulses, cuts a hang short
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (bvalid) cmp_b(bresp, bq.pop_front());
        if (rvalid) cmp_r({rresp, rdata}, rq.pop_front());
        if (wdtResetPulse) begin
            nPulse++;
            tPulse = $time;
        end
        if (cyc == 30000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    initial begin
        {rst_n, extPinReset, brownoutReset, testPortCoreReset, watchdogAlwaysOnFuse, restartInstr} = 6'h00;
        {awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
        rng = 32'hdfc7_52d2;
        wstrb = 4'hf;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(ST, 34'h01);
        rd(CT, 34'h00);
        wr(ST, 32'h1f, OK);
        rd(ST, 34'h01);
        wr(ST, 32'h00, OK);
        rd(ST, 34'h00);
        rng = xs(rng);
        wr(CT, {rng[31:5], 5'h0f}, OK);
        rd(CT, 34'h08);
        wr(CT, 32'h00, OK);
        rd(CT, 34'h08);
        wr(CT, 32'h18, OK);
        repeat (6) @(posedge clk_sys);
        wr(CT, 32'h03, OK);
        rd(CT, 34'h08);
        wr(CT, 32'h18, OK);
        wr(CT, 32'h02, OK);
        rd(CT, 34'h02);
        cmp_v(32'(watchdogActive), 32'h0);
        // Codes 0 to 3 each time out after their own tick count, then flag and reset
        for (int p = 0; p < 4; p++) begin
            wr(CT, 32'h18, OK);
            wr(CT, 32'(8 + p), OK);
            restart_pin();
            t0 = $time;
            n0 = nPulse;
            while (nPulse == n0) @(posedge clk_sys);
            cmp_v(32'(tPulse - t0 > ((TB << p) - 1) * 1000 && tPulse - t0 < ((TB << p) + 1) * 1000), 32'h1);
            rd(ST, 34'h08);
            rd(CT, 34'h00);
        end
        // Restarts by pin and register keep the shortest timeout away
        wr(CT, 32'h08, OK);
        n0 = nPulse;
        for (int i = 0; i < 12; i++) begin
            repeat (15) @(posedge clk_sys);
            if (i[0]) wr(RS, 32'h01, OK);
            else restart_pin();
        end
        wr(CT, 32'h18, OK);
        wr(CT, 32'h00, OK);
        repeat (100) @(posedge clk_sys);
        cmp_v(32'(nPulse - n0), 32'h0);
        rd(RS, 34'h00);
        // Outside reset sources, one at a time
        for (int i = 0; i < 3; i++) begin
            wr(ST, 32'h00, OK);
            {extPinReset, brownoutReset, testPortCoreReset} <= 3'h4 >> i;
            repeat (4) @(posedge clk_sys);
            {extPinReset, brownoutReset, testPortCoreReset} <= 3'h0;
            repeat (6) @(posedge clk_sys);
            rd(ST, 34'(flagBit[i]));
        end
        // Lane 0 disabled: the clearing write is answered but changes nothing
        wstrb <= 4'he;
        wr(ST, 32'h00, OK);
        wstrb <= 4'hf;
        rd(ST, 34'h10);
        wr(8'h0c, 32'h01, `WDG_RESP_SLVERR);
        rd(8'h0c, {`WDG_RESP_SLVERR, 32'h0});
        // Second power-on with the fuse programmed, restart held so nothing fires yet
        rst_n <= 1'b0;
        watchdogAlwaysOnFuse <= 1'b1;
        restartInstr <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rd(ST, 34'h01);
        rd(CT, 34'h08);
        rng = xs(rng);
        wr(CT, 32'h18, OK);
        wr(CT, 32'(rng[2:0]), OK);
        rd(CT, 34'(8'h08 | rng[2:0]));
        cmp_v(32'(watchdogActive), 32'h1);
        restartInstr <= 1'b0;
        n0 = nPulse;
        while (nPulse == n0) @(posedge clk_sys);
        repeat (3) @(posedge clk_sys);
        rd(ST, 34'h09);
        rd(CT, 34'h08);
        tally_and_finish();
    end
endmodule // tb_top

// ===== verification/wdg_top_asserts.sv
// Concurrent checks on the ports of the watchdog top
`timescale 1ns/1ns
module wdg_top_asserts (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic watchdogAlwaysOnFuse,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic [31:0] rdata,
    input wire logic wdtResetPulse,
    input wire logic watchdogActive
);
    // Cycles since reset release, saturating; the fuse needs a few cycles to settle
    logic [3:0] upCnt;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            upCnt <= 4'h0;
        end else if (upCnt != 4'hf) begin
            upCnt <= upCnt + 4'h1;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // Address and data taken at one edge
    sequence s_wr_take;
        awvalid && awready && wvalid && wready;
    endsequence
    // Read address taken
    sequence s_rd_take;
        arvalid && arready;
    endsequence

    property p_pulse_single;
        wdtResetPulse |=> !wdtResetPulse;
    endproperty
    a_pulse_single: assert property (p_pulse_single) else $error("reset pulse longer than one cycle");
    property p_pulse_active;
        wdtResetPulse |-> watchdogActive;
    endproperty
    a_pulse_active: assert property (p_pulse_active) else $error("reset pulse while idle");
    property p_pulse_drops;
        wdtResetPulse && !watchdogAlwaysOnFuse |-> ##[1:3] !watchdogActive;
    endproperty
    a_pulse_drops: assert property (p_pulse_drops) else $error("chip reset left watchdog running");
    property p_level2_on;
        watchdogAlwaysOnFuse && upCnt > 4'h7 |-> watchdogActive;
    endproperty
    a_level2_on: assert property (p_level2_on) else $error("level two watchdog stopped");
    property p_b_answer;
        s_wr_take |-> ##2 bvalid;
    endproperty
    a_b_answer: assert property (p_b_answer) else $error("write answer late");
    property p_b_busy;
        bvalid |-> !awready && !wready;
    endproperty
    a_b_busy: assert property (p_b_busy) else $error("write channel ready during answer");
    property p_r_answer;
        s_rd_take |=> rvalid && rdata[31:8] == 24'h00_0000;
    endproperty
    a_r_answer: assert property (p_r_answer) else $error("read answer late or upper bits set");
    property p_r_busy;
        rvalid |-> !arready;
    endproperty
    a_r_busy: assert property (p_r_busy) else $error("read channel ready during answer");
endmodule // wdg_top_asserts

bind wdg_top wdg_top_asserts u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .watchdogAlwaysOnFuse(watchdogAlwaysOnFuse),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
    .arready(arready), .rvalid(rvalid), .rdata(rdata), .wdtResetPulse(wdtResetPulse), .watchdogActive(watchdogActive));
